// [src/cfgf_cfg.svh]
/*
 Constants of the compressed frame gap formatter: register offsets,
 field positions and reset values. Assumes a 32-bit APB with byte addresses.
*/
// Function
// R1: no data in slots first through last gap; type A still sends Data1 of the first slot
// R2: compression periodic or on demand, never fixed
// R3: raise transmit gain per reduction method
// R4: type A silent TFCI first to Data2 last
// R5: type B silent Data2 first to Data2 last
// R6: type B sends dummy TFCI, Data1 first slot
// R7: both ends use only TPC of first slot
// R8: type B only where gap still fits
// R9: both methods downlink, uplink spreading only
// R10: spreading method halves spreading factor
// R11: reject idle portion above seven slots
// R12: puncturing makes gap within one frame
// R13: unused punctured data positions sent as DTX
// R14: punctured frame keeps normal field widths
// R15: no TFCI used means DTX in TFCI
// R16: no puncturing with TFCI at SF 512
// R17: first gap slot not above last slot
// R18: latch settings at frame boundary only
`ifndef CFGF_CFG_SVH
`define CFGF_CFG_SVH
// Register byte offsets.
`define CFGF_A_CTRL   8'h00
`define CFGF_A_GAP    8'h04
`define CFGF_A_FLD0   8'h08
`define CFGF_A_FLD1   8'h0C
`define CFGF_A_GAIN   8'h10
`define CFGF_A_QUOTA  8'h14
`define CFGF_A_STAT   8'h18
// Control bits.
`define CFGF_C_EN     0
`define CFGF_C_PER    1
`define CFGF_C_ONCE   2
`define CFGF_C_TYPB   3
`define CFGF_C_MSF    4
`define CFGF_C_UPL    5
`define CFGF_C_TFON   6
`define CFGF_C_SF512  7
`define CFGF_C_W      7:0
// Field positions.
`define CFGF_G_FIRST  3:0
`define CFGF_G_LAST   11:8
`define CFGF_F_D1     9:0
`define CFGF_F_D2     25:16
`define CFGF_F_TFCI   3:0
`define CFGF_F_TPC    11:8
`define CFGF_F_PIL    20:16
`define CFGF_GN_NORM  7:0
`define CFGF_GN_PUNC  15:8
`define CFGF_GN_SF    23:16
`define CFGF_GN_W     23:0
`define CFGF_Q_W      13:0
`define CFGF_S_SLOT   3:0
`define CFGF_S_ACT    8
`define CFGF_S_REJ    16
`define CFGF_S_UND    17
// Frame figures and reset values.
`define CFGF_LAST_SLOT 4'hE
`define CFGF_MAX_IDLE  4'h7
`define CFGF_RST_TPC   4'h2
`define CFGF_RST_PIL   5'h02
`define CFGF_DUMMY     2'h0
`define CFGF_NOSYM     2'h0
`endif

// [src/cfgf_pkg.sv]
/*
 Types of the compressed frame gap formatter.
 Assumes the constants header is included by the design files.
*/
package cfgf_pkg;
   // Slot fields in transmission order.
   typedef enum logic [2:0] {F_DATA1, F_TPC, F_TFCI, F_DATA2, F_PILOT} cfgf_fld_type;
endpackage : cfgf_pkg

// [src/cfgf_fifo.sv]
/*
 Small symbol FIFO with valid and ready on both sides.
 Assumes D is a power of two and one clock for both sides.
*/
`timescale 1ns/10ps
module cfgf_fifo #(
   parameter int W = 2,
   parameter int D = 4
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Filling side.
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // Draining side.
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW+1)'(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
      logic                rdy;
      logic                vld;
   } cfgf_fifo_state_type;

   cfgf_fifo_state_type s;
   cfgf_fifo_state_type next_s;
   logic                push;
   logic                pop;

   // Pointer and count update; flags are registered so ready stalls honestly.
   always_comb begin
      next_s = s;
      push = in_valid & s.rdy;
      pop = out_ready & s.vld;
      if (push) begin
         next_s.mem[s.wp] = in_data;
         next_s.wp = s.wp + 1'b1;
      end
      if (pop) begin
         next_s.rp = s.rp + 1'b1;
      end
      next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      next_s.rdy = (next_s.cnt != FULL);
      next_s.vld = (next_s.cnt != '0);
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.rdy <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign in_ready = s.rdy;
   assign out_valid = s.vld;
   assign out_data = s.mem[s.rp];
endmodule : cfgf_fifo

// [src/cfgf_top.sv]
/*
 Slot formatter for compressed downlink and uplink frames: opens the
 transmission gap, gates the slot fields by structure type, applies the
 reduction method, fills unused data positions with DTX and raises gain.
 Assumes sym_tick marks each symbol and frame_start comes with the tick
 of slot 0, first symbol. Registers are reached over APB.
*/
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "cfgf_cfg.svh"
module cfgf_top
   import cfgf_pkg::*;
(
   // Clock and reset.
   input  wire logic   pclk,
   input  wire logic   presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Symbol timing.
   input  wire logic        frame_start,
   input  wire logic        sym_tick,
   // Data symbols in.
   input  wire logic        in_valid,
   input  wire logic [1:0]  in_data,
   output logic             in_ready,
   // Control field symbols (TPC, TFCI, pilot).
   input  wire logic [1:0]  ctl_sym,
   // Formatted symbol out.
   output logic             tx_valid,
   output logic [1:0]       tx_sym,
   output cfgf_fld_type     tx_fld,
   output logic [3:0]       tx_slot,
   output logic             tx_on,
   output logic             tx_dtx,
   output logic             tx_dummy,
   // Frame levels.
   output logic [7:0]       tx_gain,
   output logic             sf_half,
   output logic             cmp_active
);
   typedef struct packed {
      logic [7:0]   ctrl;
      logic [3:0]   gf_r;
      logic [3:0]   gl_r;
      logic [9:0]   n_d1;
      logic [9:0]   n_d2;
      logic [3:0]   n_tfci;
      logic [3:0]   n_tpc;
      logic [4:0]   n_pil;
      logic [23:0]  gain;
      logic [13:0]  quota;
      logic         rej;
      logic         und;
      logic         cmp;
      logic         typ_b;
      logic         msf;
      logic         tfon;
      logic [3:0]   gf;
      logic [3:0]   gl;
      logic [13:0]  left;
      logic [3:0]   slot;
      cfgf_fld_type fld;
      logic [9:0]   pos;
      logic         pready;
      logic         pslverr;
      logic [31:0]  prdata;
      logic         tx_valid;
      logic [1:0]   tx_sym;
      cfgf_fld_type tx_fld;
      logic [3:0]   tx_slot;
      logic         tx_on;
      logic         tx_dtx;
      logic         tx_dummy;
      logic [7:0]   tx_gain;
      logic         sf_half;
   } cfgf_state_type;

   cfgf_state_type s;
   cfgf_state_type next_s;
   logic           f_vld;
   logic [1:0]     f_data;
   logic           f_pop;
   logic           req;
   logic           ok;
   logic [3:0]     cs;
   cfgf_fld_type   cf;
   logic [9:0]     cp;
   logic [9:0]     wid;
   logic           off;
   logic           dum;

   ////////////////////////////////////////////////////////////////////////
   // Four-word buffer in the data path; its ready stalls the source.
   cfgf_fifo #(
      .W (2),
      .D (4)
   ) u_fifo (
      .clk       (pclk),
      .rst_n     (presetn),
      .in_valid  (in_valid),
      .in_data   (in_data),
      .in_ready  (in_ready),
      .out_valid (f_vld),
      .out_data  (f_data),
      .out_ready (f_pop)
   );

   // Width of a slot field in symbols.
   function automatic logic [9:0] fwid(input cfgf_fld_type f, input cfgf_state_type t);
      logic [9:0] w;
      w = '0;
      case (f)
         F_DATA1: w = t.n_d1;
         F_TPC:   w = {6'h00, t.n_tpc};
         F_TFCI:  w = {6'h00, t.n_tfci};
         F_DATA2: w = t.n_d2;
         F_PILOT: w = {5'h00, t.n_pil};
         default: w = '0;
      endcase
      return w;
   endfunction : fwid

   ////////////////////////////////////////////////////////////////////////
   // Bus access, frame latch, symbol formatting and slot walk.
   always_comb begin
      next_s = s;
      next_s.pready = 1'b0;
      next_s.tx_valid = 1'b0;
      f_pop = 1'b0;
      cs = s.slot;
      cf = s.fld;
      cp = s.pos;
      off = 1'b0;
      dum = 1'b0;
      wid = '0;
      req = 1'b0;
      ok = 1'b0;
      // Register writes and reads; one wait state per access.
      if (psel && penable && !s.pready) begin
         next_s.pready = 1'b1;
         next_s.pslverr = 1'b0;
         next_s.prdata = '0;
         case (paddr)
            `CFGF_A_CTRL: begin
               if (pwrite) next_s.ctrl = pwdata[`CFGF_C_W];
               next_s.prdata[`CFGF_C_W] = s.ctrl;
            end
            `CFGF_A_GAP: begin
               if (pwrite) begin
                  next_s.gf_r = pwdata[`CFGF_G_FIRST];
                  next_s.gl_r = pwdata[`CFGF_G_LAST];
               end
               next_s.prdata[`CFGF_G_FIRST] = s.gf_r;
               next_s.prdata[`CFGF_G_LAST] = s.gl_r;
            end
            `CFGF_A_FLD0: begin
               if (pwrite) begin
                  next_s.n_d1 = pwdata[`CFGF_F_D1];
                  next_s.n_d2 = pwdata[`CFGF_F_D2];
               end
               next_s.prdata[`CFGF_F_D1] = s.n_d1;
               next_s.prdata[`CFGF_F_D2] = s.n_d2;
            end
            `CFGF_A_FLD1: begin
               if (pwrite) begin
                  next_s.n_tfci = pwdata[`CFGF_F_TFCI];
                  next_s.n_tpc = pwdata[`CFGF_F_TPC];
                  next_s.n_pil = pwdata[`CFGF_F_PIL];
               end
               next_s.prdata[`CFGF_F_TFCI] = s.n_tfci;
               next_s.prdata[`CFGF_F_TPC] = s.n_tpc;
               next_s.prdata[`CFGF_F_PIL] = s.n_pil;
            end
            `CFGF_A_GAIN: begin
               if (pwrite) next_s.gain = pwdata[`CFGF_GN_W];
               next_s.prdata[`CFGF_GN_W] = s.gain;
            end
            `CFGF_A_QUOTA: begin
               if (pwrite) next_s.quota = pwdata[`CFGF_Q_W];
               next_s.prdata[`CFGF_Q_W] = s.quota;
            end
            `CFGF_A_STAT: begin
               // Write one to clear; a new event below still wins.
               if (pwrite && pwdata[`CFGF_S_REJ]) next_s.rej = 1'b0;
               if (pwrite && pwdata[`CFGF_S_UND]) next_s.und = 1'b0;
               next_s.prdata[`CFGF_S_SLOT] = s.slot;
               next_s.prdata[`CFGF_S_ACT] = s.cmp;
               next_s.prdata[`CFGF_S_REJ] = s.rej;
               next_s.prdata[`CFGF_S_UND] = s.und;
            end
            default: next_s.pslverr = 1'b1;
         endcase
      end
      // Frame boundary: decide compression and freeze settings.
      if (sym_tick && frame_start) begin
         req = s.ctrl[`CFGF_C_EN] & (s.ctrl[`CFGF_C_PER] | s.ctrl[`CFGF_C_ONCE]); // see R2
         ok = (s.gf_r <= s.gl_r) && (s.gl_r <= `CFGF_LAST_SLOT); // see R17
         ok = ok && ((s.gl_r - s.gf_r) < `CFGF_MAX_IDLE); // see R11
         if (s.ctrl[`CFGF_C_UPL] && !s.ctrl[`CFGF_C_MSF]) ok = 1'b0; // see R9
         if (s.ctrl[`CFGF_C_UPL] && s.ctrl[`CFGF_C_TYPB]) ok = 1'b0; // see R8
         if (!s.ctrl[`CFGF_C_MSF] && s.ctrl[`CFGF_C_SF512] && s.ctrl[`CFGF_C_TFON]) begin
            ok = 1'b0; // see R16
         end
         next_s.cmp = req & ok;
         if (req && !ok) next_s.rej = 1'b1;
         if (req) next_s.ctrl[`CFGF_C_ONCE] = 1'b0;
         next_s.gf = s.gf_r; // see R18
         next_s.gl = s.gl_r;
         next_s.typ_b = s.ctrl[`CFGF_C_TYPB];
         next_s.msf = s.ctrl[`CFGF_C_MSF];
         next_s.tfon = s.ctrl[`CFGF_C_TFON];
         next_s.left = s.quota; // see R12
         cs = '0;
         cf = (s.n_d1 != '0) ? F_DATA1 : F_TPC;
         cp = '0;
      end
      if (sym_tick) begin
         // Gap window: off from the start field of the first slot to Data2 of the last.
         if (next_s.cmp && cs >= next_s.gf && cs <= next_s.gl) begin // see R1
            off = 1'b1;
            if (cs == next_s.gf && next_s.typ_b) off = (cf >= F_DATA2); // see R5
            if (cs == next_s.gf && !next_s.typ_b) off = (cf >= F_TFCI); // see R4
            if (cs == next_s.gl && cf == F_PILOT) off = 1'b0;
            dum = next_s.typ_b && cs == next_s.gf && (cf == F_DATA1 || cf == F_TFCI); // see R6
         end
         next_s.tx_valid = 1'b1;
         next_s.tx_fld = cf;
         next_s.tx_slot = cs;
         next_s.tx_on = !off;
         next_s.tx_dummy = dum;
         next_s.tx_dtx = 1'b0;
         next_s.tx_sym = `CFGF_NOSYM;
         if (off || dum) begin
            if (dum) next_s.tx_sym = `CFGF_DUMMY; // see R7
         end else if (cf == F_DATA1 || cf == F_DATA2) begin
            if (next_s.cmp && !next_s.msf && next_s.left == '0) begin
               next_s.tx_dtx = 1'b1; // see R13
            end else if (f_vld) begin
               f_pop = 1'b1;
               next_s.tx_sym = f_data;
               if (next_s.cmp && !next_s.msf) next_s.left = next_s.left - 1'b1; // see R14
            end else begin
               next_s.tx_dtx = 1'b1;
               next_s.und = 1'b1;
            end
         end else if (cf == F_TFCI && next_s.cmp && !next_s.tfon) begin
            next_s.tx_dtx = 1'b1; // see R15
         end else begin
            next_s.tx_sym = ctl_sym;
         end
         // Advance to the next symbol, skipping an empty Data1 or TFCI field.
         wid = fwid(cf, s);
         next_s.slot = cs;
         next_s.fld = cf;
         next_s.pos = cp + 1'b1;
         if (next_s.pos >= wid) begin
            next_s.pos = '0;
            case (cf)
               F_DATA1: next_s.fld = F_TPC;
               F_TPC:   next_s.fld = (s.n_tfci != '0) ? F_TFCI : F_DATA2;
               F_TFCI:  next_s.fld = F_DATA2;
               F_DATA2: next_s.fld = F_PILOT;
               F_PILOT: begin
                  next_s.fld = (s.n_d1 != '0) ? F_DATA1 : F_TPC;
                  if (cs == `CFGF_LAST_SLOT) begin
                     next_s.slot = '0;
                     next_s.cmp = 1'b0;
                  end else begin
                     next_s.slot = cs + 1'b1;
                  end
               end
               default: next_s.fld = F_DATA1;
            endcase
         end
      end
      // Gain and spreading follow the frame's latched method.
      next_s.tx_gain = next_s.gain[`CFGF_GN_NORM];
      if (next_s.cmp) next_s.tx_gain = next_s.msf ? next_s.gain[`CFGF_GN_SF] // see R3
                                                  : next_s.gain[`CFGF_GN_PUNC];
      next_s.sf_half = next_s.cmp & next_s.msf; // see R10
   end

   ////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.n_tpc <= `CFGF_RST_TPC;
         s.n_pil <= `CFGF_RST_PIL;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register.
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign tx_valid = s.tx_valid;
   assign tx_sym = s.tx_sym;
   assign tx_fld = s.tx_fld;
   assign tx_slot = s.tx_slot;
   assign tx_on = s.tx_on;
   assign tx_dtx = s.tx_dtx;
   assign tx_dummy = s.tx_dummy;
   assign tx_gain = s.tx_gain;
   assign sf_half = s.sf_half;
   assign cmp_active = s.cmp;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the APB answer, the frame decision, the latched settings and the formatted stream.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_acc;
      psel && penable && !s.pready;
   endsequence
   sequence s_done;
      s.pready ##1 !s.pready;
   endsequence

   a_apb_answer: assert property (s_acc |=> s_done)
      else $error("APB access not answered in one wait state.");
   a_mid_silent: assert property ( // see R1
      s.tx_valid && s.cmp && s.tx_slot > s.gf && s.tx_slot < s.gl |-> !s.tx_on)
      else $error("Symbol sent inside the gap.");
   a_typea_gap: assert property ( // see R4
      s.tx_valid && s.cmp && !s.typ_b && s.tx_slot == s.gf && s.tx_fld == F_TFCI
      |-> !s.tx_on)
      else $error("Type A TFCI of first gap slot not silent.");
   a_typeb_gap: assert property ( // see R5
      s.tx_valid && s.cmp && s.typ_b && s.tx_slot == s.gf
      |-> (s.tx_fld == F_TPC) ? s.tx_on : (s.tx_fld != F_DATA2 || !s.tx_on))
      else $error("Type B first gap slot gated wrongly.");
   a_typeb_dummy: assert property ( // see R6
      s.tx_valid && s.cmp && s.typ_b && s.tx_slot == s.gf && s.tx_fld == F_DATA1
      |-> s.tx_dummy)
      else $error("Type B Data1 of first gap slot not dummy.");
   a_gain_up: assert property ( // see R3
      $rose(s.cmp) |-> s.tx_gain == (s.msf ? s.gain[`CFGF_GN_SF] : s.gain[`CFGF_GN_PUNC]))
      else $error("Gain not raised for compressed frame.");
   a_sf_half: assert property ( // see R10
      $rose(s.cmp) && s.msf |-> s.sf_half)
      else $error("Spreading factor not halved.");
   a_idle_reject: assert property ( // see R11
      sym_tick && frame_start && (s.gl_r - s.gf_r) >= `CFGF_MAX_IDLE
      |=> !s.cmp)
      else $error("Overlong gap accepted.");
   a_quota_dtx: assert property ( // see R13
      s.tx_valid && s.cmp && !s.msf && s.tx_on && !s.tx_dummy
      && (s.tx_fld == F_DATA1 || s.tx_fld == F_DATA2)
      && $past(s.left) == '0 && !$past(frame_start)
      |-> s.tx_dtx)
      else $error("Data sent after puncturing quota.");
   a_tfci_dtx: assert property ( // see R15
      s.tx_valid && s.cmp && !s.tfon && s.tx_fld == F_TFCI && s.tx_on && !s.tx_dummy
      |-> s.tx_dtx)
      else $error("Unused TFCI not sent as DTX.");
   a_cfg_hold: assert property ( // see R18
      !(sym_tick && frame_start) |=> $stable({s.gf, s.gl, s.typ_b, s.msf, s.tfon}))
      else $error("Frame settings changed inside a frame.");
endmodule : cfgf_top

// [sim/cfgf_peer.sv]
/*
 Far-side model: offers data symbols, feeds control symbols and counts
 the data symbols that really go on air. Assumes one clock, pclk.
*/
`timescale 1ns/10ps
module cfgf_peer
   import cfgf_pkg::*;
(
   // Clock and reset.
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Control from the bench.
   input  wire logic         go,
   input  wire logic         clr,
   // Data offer.
   input  wire logic         in_ready,
   output logic              in_valid,
   output logic [1:0]        in_data,
   output logic [1:0]        ctl_sym,
   // Air side.
   input  wire logic         tx_valid,
   input  wire logic         tx_on,
   input  wire logic         tx_dtx,
   input  wire logic         tx_dummy,
   input  wire cfgf_fld_type tx_fld,
   output logic [31:0]       n_sent,
   output logic [31:0]       n_data
);
   ////////////////////////////////////////////////////////////////////
   // An offer is held until taken; filler symbols are never counted.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_valid <= 1'b0;
         in_data  <= 2'h0;
         ctl_sym  <= 2'h0;
         n_sent   <= 32'h0;
         n_data   <= 32'h0;
      end else begin
         ctl_sym <= ~ctl_sym;
         if (in_valid && in_ready) begin
            n_sent  <= n_sent + 32'h1;
            in_data <= in_data + 2'h1;
         end
         if (!in_valid || in_ready) in_valid <= go;
         if (clr) n_data <= 32'h0;
         else if (tx_valid && tx_on && !tx_dtx && !tx_dummy &&
                  (tx_fld == F_DATA1 || tx_fld == F_DATA2))
            n_data <= n_data + 32'h1;
      end
   end
endmodule : cfgf_peer

// [sim/test_compressed_frame_gap_formatter.sv]
/*
 Testbench of the gap formatter: APB set-up, whole frames, gap shape,
 gain levels, rejection and the symbol FIFO. Assumes a 200 MHz pclk.
*/
`timescale 1ns/10ps
module test_compressed_frame_gap_formatter;
   import cfgf_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, tx_gain;
   logic [31:0] pwdata, prdata, r, n_sent, n_data;
   logic frame_start, sym_tick, in_valid, in_ready, tx_valid, tx_on, tx_dtx;
   logic tx_dummy, sf_half, cmp_active, go, clr, e;
   logic [1:0] in_data, ctl_sym, tx_sym;
   logic [3:0] tx_slot, cf, cl;
   cfgf_fld_type tx_fld;
   logic cmpx, cb, cm, ct;
   int n_errors, n_tests;

   cfgf_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_start(frame_start), .sym_tick(sym_tick), .in_valid(in_valid),
      .in_data(in_data), .in_ready(in_ready), .ctl_sym(ctl_sym),
      .tx_valid(tx_valid), .tx_sym(tx_sym), .tx_fld(tx_fld),
      .tx_slot(tx_slot), .tx_on(tx_on), .tx_dtx(tx_dtx),
      .tx_dummy(tx_dummy), .tx_gain(tx_gain), .sf_half(sf_half),
      .cmp_active(cmp_active));
   cfgf_peer peer_u (.pclk(pclk), .presetn(presetn), .go(go), .clr(clr),
      .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data),
      .ctl_sym(ctl_sym), .tx_valid(tx_valid), .tx_on(tx_on),
      .tx_dtx(tx_dtx), .tx_dummy(tx_dummy), .tx_fld(tx_fld),
      .n_sent(n_sent), .n_data(n_data));

   ////////////////////////////////////////////////////////////////////
   // Shared comparison, bus cycle and verdict.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic conclude();
      if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////
   // Expected air state of one symbol position.
   function automatic logic exp_on(logic [3:0] s, cfgf_fld_type f);
      if (!cmpx || s < cf || s > cl) return 1'b1;
      if (s == cl && f == F_PILOT) return 1'b1;
      if (s > cf) return 1'b0;
      return cb ? f < F_DATA2 : f < F_TFCI;
   endfunction : exp_on

   // Watches every formatted symbol of the stream.
   always @(posedge pclk) begin
      if (presetn && tx_valid === 1'b1) begin
         chk(32'(tx_on), 32'(exp_on(tx_slot, tx_fld)));
         chk(32'(tx_dummy), 32'(cmpx && cb && tx_slot == cf &&
             (tx_fld == F_DATA1 || tx_fld == F_TFCI)));
         if (tx_dummy === 1'b1) chk(32'(tx_sym), 32'h0);
         if (cmpx && !ct && tx_fld == F_TFCI && tx_on === 1'b1 && tx_dummy !== 1'b1)
            chk(32'(tx_dtx), 32'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // One frame of 180 symbols, a tick every second cycle.
   task automatic run(input logic cmp);
      cmpx = cmp;
      for (int i = 0; i < 362; i++) begin
         @(posedge pclk);
         if (i == 2) begin
            chk(32'(cmp_active), 32'(cmp));
            chk(32'(tx_gain), !cmp ? 32'h10 : cm ? 32'h30 : 32'h20);
            chk(32'(sf_half), 32'(cmp && cm));
         end
         sym_tick    <= (i % 2 == 0) && i < 360;
         frame_start <= i == 0;
         clr         <= i == 0;
      end
      if (cmp && !cm && go) chk(n_data, 32'h5);
   endtask : run

   task automatic frame(input logic [7:0] c, input logic [3:0] f, input logic [3:0] l,
                        input logic cmp);
      apb(1'b1, 8'h04, {20'h0, l, 4'h0, f});
      apb(1'b1, 8'h00, {24'h0, c});
      cb = c[3];
      cm = c[4];
      ct = c[6];
      cf = f;
      cl = l;
      run(cmp);
   endtask : frame

   ////////////////////////////////////////////////////////////////////
   // Clock, watchdog and the sequence of scenarios.
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   initial begin
      #100000;
      n_errors++;
      conclude();
   end

   initial begin
      {psel, penable, pwrite, frame_start, sym_tick, go, clr} = '0;
      {paddr, pwdata, cmpx, cb, cm, ct, cf, cl} = '0;
      n_errors = 0;
      n_tests  = 0;
      presetn  = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h0C, 32'h0);
      chk(r, 32'h00020200);
      apb(1'b0, 8'h1C, 32'h0);
      chk(32'(e), 32'h1);
      apb(1'b1, 8'h02, 32'h0);
      chk(32'(e), 32'h1);
      go <= 1'b1;
      repeat (10) @(posedge pclk);
      chk(32'(in_ready), 32'h0);
      chk(n_sent, 32'h4);
      apb(1'b1, 8'h08, 32'h00040002);
      apb(1'b1, 8'h0C, 32'h00020202);
      apb(1'b1, 8'h10, 32'h00302010);
      apb(1'b1, 8'h14, 32'h5);
      frame(8'h45, 4'h3, 4'h5, 1'b1);
      run(1'b0);
      frame(8'h1B, 4'h3, 4'h5, 1'b1);
      run(1'b1);
      frame(8'h05, 4'h7, 4'h7, 1'b1);
      frame(8'h05, 4'h2, 4'h8, 1'b1);
      frame(8'h35, 4'h3, 4'h5, 1'b1);
      frame(8'h05, 4'h2, 4'h9, 1'b0);
      frame(8'h05, 4'h5, 4'h3, 1'b0);
      frame(8'h25, 4'h3, 4'h5, 1'b0);
      frame(8'h3D, 4'h3, 4'h5, 1'b0);
      frame(8'hC5, 4'h3, 4'h5, 1'b0);
      apb(1'b0, 8'h18, 32'h0);
      chk(r & 32'h00010000, 32'h00010000);
      apb(1'b1, 8'h18, 32'h00030000);
      apb(1'b0, 8'h18, 32'h0);
      chk(r & 32'h00030000, 32'h0);
      go <= 1'b0;
      run(1'b0);
      apb(1'b0, 8'h18, 32'h0);
      chk(r & 32'h00020000, 32'h00020000);
      conclude();
   end
endmodule : test_compressed_frame_gap_formatter
